// ---- core/lcec_pkg.sv ----
// Package of constants for the line-cycle energy calibration block
// Function
// RULE_01: Calibration mode while mode bit 7 set
// RULE_02: Half cycles delimited by voltage zero crossings
// RULE_03: Accumulate for half-cycle count field half cycles
// RULE_04: Count supports one to 255 half cycles
// RULE_05: Period end sets flag, drives event pin low
// RULE_06: Enabled event also drives interrupt pin low
// RULE_07: New period starts automatically while enabled
// RULE_08: Host discards first period result
// RULE_09: Accumulator updated every four master clocks
// RULE_10: Pulse rate divided by divider plus one
// RULE_11: Signed twelve-bit gain trim, 0.0244 percent steps
// RULE_12: Sample rate select gives clock/128 to /1024
// RULE_13: Phase trim step is sixteen master clocks
// RULE_14: Serial transfers timed by serial clock only
// RULE_15: Energy accumulator holds signed value
// RULE_16: Forty-bit signed accumulator wraps around
// RULE_17: Pulse on 24-bit register top bit rising
// RULE_18: Pulse divider resets to 3F hex
// RULE_19: Counter reloads, decrements per crossing, ends at zero; code ends at count one and reloads before zero
// RULE_20: Accumulator cleared at period start crossing
package lcec_pkg;
   localparam int MODE_CAL_BIT = 7;
   localparam int POWER_W = 16;
   localparam int ENERGY_W = 40;
   localparam int PULSE_ACC_W = 24;
   localparam int DIV_W = 12;
   localparam int GAIN_W = 12;
   localparam int GAIN_SHIFT = 12;
   localparam int PHASE_W = 6;
   localparam int UPDATE_DIV = 4;
   localparam int PHASE_STEP_CLKS = 16;
   localparam int SAMPLE_DIV_MIN_LOG2 = 7;
   localparam int HALF_CYC_W = 8;
   localparam logic [11:0] PULSE_DIV_RESET = 12'h03F;
   localparam logic [7:0] HALF_CYC_RESET = 8'hFF;
   localparam logic [7:0] MODE_RESET = 8'h00;
endpackage

// ---- core/lcec_counter.sv ----
// Reloadable down counter with terminal flag
`timescale 1ns/10ps
`default_nettype none
module lcec_counter #(
   parameter int W = 8
) (
   // Clocking
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   // Control
   input wire logic load,
   input wire logic [W-1:0] load_value,
   input wire logic dec,
   // Status
   output logic [W-1:0] count,
   output logic zero
);
   logic [W-1:0] next_count;

   always_comb begin
      next_count = count;
      if (load) begin
         next_count = load_value;
      end else if (dec && count != '0) begin
         next_count = count - W'(1);
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         count <= '0;
      end else if (ce) begin
         count <= next_count;
      end
   end

   assign zero = (count == '0);
endmodule
`default_nettype wire

// ---- core/lcec_top.sv ----
// Line-cycle energy calibration, pulse output and rate generation
`timescale 1ns/10ps
`default_nettype none
module lcec_top
   import lcec_pkg::*;
(
   // Clocking
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   // Configuration, levels on mclk; no serial clock reaches this block
   input wire logic [7:0] mode_config, // RULE_14
   input wire logic [HALF_CYC_W-1:0] half_cycle_count,
   input wire logic [DIV_W-1:0] pulse_divider,
   input wire logic pulse_divider_wr,
   input wire logic [GAIN_W-1:0] power_gain_trim,
   input wire logic [1:0] sample_rate_select,
   input wire logic [PHASE_W-1:0] phase_trim,
   input wire logic event_irq_enable,
   input wire logic event_flag_clear,
   // Signal path
   input wire logic signed [POWER_W-1:0] power_lowpass,
   input wire logic zero_cross_pin,
   // Results
   output logic signed [ENERGY_W-1:0] energy_accumulator,
   output logic event_flag,
   output logic event_n,
   output logic irq_n,
   output logic energy_pulse_out,
   output logic sample_strobe,
   output logic phase_strobe,
   output logic [DIV_W-1:0] pulse_divider_value
);
   // ****************************************************
   // Zero-crossing input synchroniser
   // ****************************************************
   typedef enum logic [1:0] {
      LCEC_IDLE = 2'b00,
      LCEC_ARM = 2'b01,
      LCEC_RUN = 2'b10
   } lcec_state_t;

   logic zx_s1, zx_s2, zx_s3, zx_level;
   logic next_zx_level;
   logic zx_event;

   always_comb begin
      next_zx_level = zx_level;
      if (zx_s2 == zx_s3) begin
         next_zx_level = zx_s3;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         zx_s1 <= 1'b0;
         zx_s2 <= 1'b0;
         zx_s3 <= 1'b0;
         zx_level <= 1'b0;
      end else if (ce) begin
         zx_s1 <= zero_cross_pin;
         zx_s2 <= zx_s1;
         zx_s3 <= zx_s2;
         zx_level <= next_zx_level;
      end
   end

   // Both edges of the detector output mark a half cycle
   assign zx_event = (next_zx_level != zx_level); // RULE_02

   // ****************************************************
   // Update-rate divider and gain trim
   // ****************************************************
   logic [1:0] upd_cnt, next_upd_cnt;
   logic upd_tick;
   logic signed [POWER_W+GAIN_W:0] gain_prod;
   logic signed [POWER_W-1:0] power_trim;

   always_comb begin
      next_upd_cnt = upd_cnt + 2'(1);
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         upd_cnt <= 2'h0;
      end else if (ce) begin
         upd_cnt <= next_upd_cnt;
      end
   end

   assign upd_tick = (upd_cnt == 2'(UPDATE_DIV - 1)); // RULE_09

   // Gain of 1 + trim/4096, one step is 0.0244 percent
   assign gain_prod = (power_lowpass * $signed(power_gain_trim)) >>> GAIN_SHIFT; // RULE_11
   assign power_trim = power_lowpass + POWER_W'(gain_prod); // RULE_11

   // ****************************************************
   // Calibration sequencer
   // ****************************************************
   lcec_state_t state, next_state;
   logic cnt_load, cnt_dec, cnt_zero;
   logic [HALF_CYC_W-1:0] cnt_value;
   logic cal_on;
   logic period_end;
   logic acc_clear;

   assign cal_on = mode_config[MODE_CAL_BIT]; // RULE_01

   always_comb begin
      next_state = state;
      cnt_load = 1'b0;
      cnt_dec = 1'b0;
      period_end = 1'b0;
      acc_clear = 1'b0;
      unique case (state)
         LCEC_IDLE: begin
            if (cal_on) begin
               next_state = LCEC_ARM;
            end
         end
         LCEC_ARM: begin
            if (!cal_on) begin
               next_state = LCEC_IDLE;
            end else if (zx_event && half_cycle_count != 8'h00) begin // RULE_04
               // Period opens on a crossing so it spans whole half cycles
               cnt_load = 1'b1; // RULE_19
               acc_clear = 1'b1; // RULE_20
               next_state = LCEC_RUN;
            end
         end
         LCEC_RUN: begin
            if (!cal_on) begin
               next_state = LCEC_IDLE;
            end else if (zx_event) begin
               if (cnt_value == 8'h01) begin
                  // Ending crossing also opens the next period while the half-cycle count field is nonzero
                  period_end = 1'b1; // RULE_05
                  cnt_load = 1'b1; // RULE_07
                  acc_clear = 1'b1; // RULE_20
                  if (half_cycle_count == 8'h00) begin
                     next_state = LCEC_ARM;
                  end
               end else begin
                  cnt_dec = 1'b1; // RULE_19
               end
            end
         end
         default: begin
            next_state = LCEC_IDLE;
         end
      endcase
   end

   lcec_counter #(
      .W(HALF_CYC_W)
   ) u_half_cycles (
      .mclk(mclk),
      .reset(reset),
      .ce(ce),
      .load(cnt_load),
      .load_value(half_cycle_count), // RULE_03
      .dec(cnt_dec),
      .count(cnt_value),
      .zero(cnt_zero)
   );

   // ****************************************************
   // Energy accumulator
   // ****************************************************
   // Result latched at period end so a host read sees a whole period
   logic signed [ENERGY_W-1:0] acc, next_acc;
   logic signed [ENERGY_W-1:0] next_energy;
   logic next_flag;

   always_comb begin
      next_acc = acc;
      if (acc_clear) begin
         next_acc = '0; // RULE_20
      end else if (upd_tick) begin
         next_acc = acc + ENERGY_W'(power_trim); // RULE_16
      end
      next_energy = energy_accumulator;
      if (!cal_on && upd_tick) begin
         next_energy = energy_accumulator + ENERGY_W'(power_trim); // RULE_15
      end else if (period_end) begin
         next_energy = acc; // RULE_03
      end
      next_flag = event_flag;
      if (event_flag_clear) begin
         next_flag = 1'b0;
      end
      if (period_end) begin
         next_flag = 1'b1; // RULE_05
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state <= LCEC_IDLE;
         acc <= '0;
         energy_accumulator <= '0;
         event_flag <= 1'b0;
         event_n <= 1'b1;
         irq_n <= 1'b1;
      end else if (ce) begin
         state <= next_state;
         acc <= next_acc;
         energy_accumulator <= next_energy;
         event_flag <= next_flag;
         event_n <= !next_flag; // RULE_05
         irq_n <= !(next_flag && event_irq_enable); // RULE_06
      end
   end

   // ****************************************************
   // Energy-to-frequency pulse output
   // ****************************************************
   logic [PULSE_ACC_W-1:0] pacc, next_pacc;
   logic [DIV_W-1:0] pdiv_cnt, next_pdiv_cnt;
   logic [DIV_W-1:0] next_pdiv;
   logic next_pulse;
   logic msb_rise;

   always_comb begin
      next_pacc = pacc;
      if (upd_tick) begin
         next_pacc = pacc + PULSE_ACC_W'(power_trim);
      end
      msb_rise = !pacc[PULSE_ACC_W-1] && next_pacc[PULSE_ACC_W-1]; // RULE_17
      next_pdiv_cnt = pdiv_cnt;
      next_pulse = 1'b0;
      if (msb_rise) begin
         if (pdiv_cnt >= pulse_divider_value) begin
            next_pdiv_cnt = '0;
            next_pulse = 1'b1; // RULE_10
         end else begin
            next_pdiv_cnt = pdiv_cnt + DIV_W'(1);
         end
      end
      next_pdiv = pulse_divider_value;
      if (pulse_divider_wr) begin
         next_pdiv = pulse_divider;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pacc <= '0;
         pdiv_cnt <= '0;
         energy_pulse_out <= 1'b0;
         pulse_divider_value <= PULSE_DIV_RESET; // RULE_18
      end else if (ce) begin
         pacc <= next_pacc;
         pdiv_cnt <= next_pdiv_cnt;
         energy_pulse_out <= next_pulse;
         pulse_divider_value <= next_pdiv;
      end
   end

   // ****************************************************
   // Sample rate and phase step strobes
   // ****************************************************
   logic [9:0] smp_cnt, next_smp_cnt;
   logic [9:0] smp_last;
   logic next_smp, next_ph;

   always_comb begin
      smp_last = 10'((1 << (SAMPLE_DIV_MIN_LOG2 + 32'(sample_rate_select))) - 1); // RULE_12
      next_smp = (smp_cnt >= smp_last);
      next_smp_cnt = next_smp ? 10'h000 : smp_cnt + 10'h001;
      // Trails the sample strobe by trim x 16 clocks; silent if past the period
      next_ph = (next_smp_cnt == 10'(32'(phase_trim) * PHASE_STEP_CLKS)); // RULE_13
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         smp_cnt <= 10'h000;
         sample_strobe <= 1'b0;
         phase_strobe <= 1'b0;
      end else if (ce) begin
         smp_cnt <= next_smp_cnt;
         sample_strobe <= next_smp;
         phase_strobe <= next_ph;
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************
   sequence s_cal_end;
      state == LCEC_RUN && zx_event && cnt_value == 8'h01 && cal_on;
   endsequence

   a_end_sets_flag: assert property ( // RULE_05
      @(posedge mclk) disable iff (reset) (s_cal_end and ce) |=> event_flag && !event_n)
      else $error("Period end did not raise event flag");

   a_irq_follows: assert property ( // RULE_06
      @(posedge mclk) disable iff (reset) (s_cal_end and (ce && event_irq_enable)) |=> !irq_n)
      else $error("Enabled period end did not assert interrupt");

   a_restart_auto: assert property ( // RULE_07
      @(posedge mclk) disable iff (reset)
      (s_cal_end and (ce && half_cycle_count != 8'h00)) |=> state == LCEC_RUN)
      else $error("Calibration did not restart");

   a_update_rate: assert property ( // RULE_09
      @(posedge mclk) disable iff (reset) ce && upd_tick |=> !upd_tick)
      else $error("Accumulator update faster than every four clocks");

   a_clear_start: assert property ( // RULE_20
      @(posedge mclk) disable iff (reset) ce && acc_clear |=> acc == '0)
      else $error("Accumulator not cleared at period start");

   a_reload_count: assert property ( // RULE_19
      @(posedge mclk) disable iff (reset)
      ce && cnt_load |=> cnt_value == $past(half_cycle_count))
      else $error("Half-cycle counter not reloaded");

   a_mode_gate: assert property ( // RULE_01
      @(posedge mclk) disable iff (reset) ce && !cal_on |=> state == LCEC_IDLE)
      else $error("Sequencer running outside calibration mode");

   a_divider_reset: assert property ( // RULE_18
      @(posedge mclk) $fell(reset) |-> pulse_divider_value == PULSE_DIV_RESET)
      else $error("Pulse divider reset value wrong");

   a_pulse_width: assert property ( // RULE_10
      @(posedge mclk) disable iff (reset) energy_pulse_out && ce |=> !energy_pulse_out)
      else $error("Pulse output wider than one clock");

   a_run_count: assert property ( // RULE_19
      @(posedge mclk) disable iff (reset) state == LCEC_RUN |-> !cnt_zero)
      else $error("Half-cycle counter reached zero inside a period");
endmodule
`default_nettype wire

// ---- test/lcec_line_model.sv ----
// Line voltage zero-crossing source facing the calibration block
`timescale 1ns/10ps
`default_nettype none
module lcec_line_model (
   // Clocking
   input wire logic mclk,
   input wire logic reset,
   // Line setup
   input wire logic [15:0] half_len,
   // Detector output
   output logic zero_cross_pin
);
   logic [15:0] cnt;
   // The line never stops, so crossings keep coming outside calibration too
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cnt <= 16'h0000;
         zero_cross_pin <= 1'b0;
      end else if (cnt >= half_len - 16'h0001) begin
         cnt <= 16'h0000;
         zero_cross_pin <= ~zero_cross_pin;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ---- test/lcec_top_tb.sv ----
// Self-checking bench for the line-cycle energy calibration block
`timescale 1ns/10ps
`default_nettype none
module lcec_top_tb;
   import lcec_pkg::*;
   localparam longint SKIP = 64'h7FFF_FFFF_FFFF_FFFF;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic [7:0] mode_config = 8'h00;
   logic [HALF_CYC_W-1:0] half_cycle_count = 8'h01;
   logic [DIV_W-1:0] pulse_divider = 12'h000;
   logic pulse_divider_wr = 1'b0;
   logic [GAIN_W-1:0] power_gain_trim = 12'h000;
   logic [1:0] sample_rate_select = 2'h0;
   logic [PHASE_W-1:0] phase_trim = 6'h00;
   logic event_irq_enable = 1'b0;
   logic event_flag_clear = 1'b0;
   logic signed [POWER_W-1:0] power_lowpass = 16'sh0000;
   logic [15:0] half_len = 16'h00C8;
   logic zero_cross_pin;
   logic signed [ENERGY_W-1:0] energy_accumulator;
   logic event_flag;
   logic event_n;
   logic irq_n;
   logic energy_pulse_out;
   logic sample_strobe;
   logic phase_strobe;
   logic [DIV_W-1:0] pulse_divider_value;
   int n_mismatch = 0;
   int compares = 0;
   int seed = 93;
   int cyc;
   longint exp_q[$];
   longint tol_q[$];
   longint e;
   longint tol;
   logic signed [63:0] diff;
   logic prev_flag = 1'b0;
   logic signed [ENERGY_W-1:0] frozen;

   always #4 mclk = ~mclk;

   lcec_top i_lcec_top (.mclk(mclk), .reset(reset), .ce(ce), .mode_config(mode_config),
      .half_cycle_count(half_cycle_count), .pulse_divider(pulse_divider),
      .pulse_divider_wr(pulse_divider_wr), .power_gain_trim(power_gain_trim),
      .sample_rate_select(sample_rate_select), .phase_trim(phase_trim),
      .event_irq_enable(event_irq_enable), .event_flag_clear(event_flag_clear),
      .power_lowpass(power_lowpass), .zero_cross_pin(zero_cross_pin),
      .energy_accumulator(energy_accumulator), .event_flag(event_flag), .event_n(event_n),
      .irq_n(irq_n), .energy_pulse_out(energy_pulse_out), .sample_strobe(sample_strobe),
      .phase_strobe(phase_strobe), .pulse_divider_value(pulse_divider_value));

   lcec_line_model i_lcec_line_model (.mclk(mclk), .reset(reset), .half_len(half_len),
      .zero_cross_pin(zero_cross_pin));

   // ***************
   // Shared tasks
   // ***************
   task automatic fail(input string msg);
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
   endtask

   task automatic end_sim;
      $display("compares=%0d mismatches=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [39:0] got, input logic [39:0] want, input string msg);
      compares++;
      if (got !== want) fail(msg);
   endtask

   // Counts falling edges until the chosen output is seen high
   task automatic wait_hi(input int which, input int lim);
      logic s;
      cyc = 0;
      do begin
         @(negedge mclk);
         cyc++;
         case (which)
            0: s = event_flag;
            1: s = sample_strobe;
            2: s = energy_pulse_out;
            default: s = phase_strobe;
         endcase
      end while (s !== 1'b1 && cyc < lim);
      if (s !== 1'b1) begin
         fail("wait timed out");
         end_sim();
      end
   endtask

   // First period after enable is noted but not judged
   task automatic run_cal(input int n, input int half, input int trim, input logic irq,
                          input int sgn, input int periods);
      longint p;
      longint pe;
      p = sgn * (256 + ($random(seed) & 4095));
      pe = p + ((p * trim) >>> 12);
      power_lowpass = POWER_W'(p);
      power_gain_trim = GAIN_W'(trim);
      event_irq_enable = irq;
      half_len = 16'(half);
      half_cycle_count = 8'(n);
      mode_config = 8'h80;
      for (int k = 0; k < periods; k++) begin
         exp_q.push_back(k == 0 ? SKIP : longint'(n) * half / 4 * pe);
         tol_q.push_back(2 * (pe < 0 ? -pe : pe) + 2);
         wait_hi(0, (n + 1) * half + 64);
         event_flag_clear = 1'b1;
         @(negedge mclk);
         event_flag_clear = 1'b0;
         @(negedge mclk);
         chk(40'(event_n), 40'h1, "event pin not released");
      end
      mode_config = 8'h00;
      @(negedge mclk);
   endtask

   // ***************
   // Result watcher
   // ***************
   always @(negedge mclk) begin
      if (event_flag === 1'b1 && prev_flag !== 1'b1) begin
         compares++;
         if (exp_q.size() == 0) begin
            fail("unexpected period end");
         end else begin
            e = exp_q.pop_front();
            tol = tol_q.pop_front();
            diff = energy_accumulator;
            diff = diff - e;
            if (e != SKIP && (diff < tol && diff > -tol) !== 1'b1) fail("period energy off");
         end
         if (event_n !== 1'b0 || irq_n !== !event_irq_enable) fail("event pins wrong");
      end
      prev_flag <= event_flag;
   end

   initial begin
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      chk(40'(event_n), 40'h1, "event pin at reset");
      chk(40'(irq_n), 40'h1, "irq at reset");
      chk(40'(pulse_divider_value), 40'h3F, "divider reset value");
      mode_config = 8'h7F;
      repeat (700) @(negedge mclk);
      chk(40'(event_flag), 40'h0, "period ran with mode bit clear");
      half_cycle_count = 8'h00;
      mode_config = 8'h80;
      repeat (700) @(negedge mclk);
      chk(40'(event_flag), 40'h0, "period ran with zero half-cycle count");
      mode_config = 8'h00;
      @(negedge mclk);
      run_cal(2, 200, 0, 1'b1, 1, 3);
      run_cal(1, 200, -2048, 1'b0, -1, 3);
      run_cal(255, 20, 2047, 1'b1, 1, 2);
      for (int s = 0; s < 4; s++) begin
         sample_rate_select = 2'(s);
         repeat (2) wait_hi(1, 2100);
         wait_hi(1, 2100);
         chk(40'(cyc), 40'(128 << s), "sample interval");
      end
      phase_trim = 6'($random(seed)) | 6'h01;
      wait_hi(1, 2100);
      wait_hi(3, 2100);
      chk(40'(cyc), 40'(16 * phase_trim), "phase offset");
      frozen = energy_accumulator;
      ce = 1'b0;
      repeat (20) @(negedge mclk);
      chk(energy_accumulator, frozen, "state moved with clock enable low");
      ce = 1'b1;
      repeat (8) @(negedge mclk);
      chk(40'(energy_accumulator != frozen), 40'h1, "accumulator stuck after enable");
      power_lowpass = 16'sh4000;
      power_gain_trim = 12'h000;
      for (int d = 0; d < 3; d += 2) begin
         pulse_divider = 12'(d);
         pulse_divider_wr = 1'b1;
         @(negedge mclk);
         pulse_divider_wr = 1'b0;
         @(negedge mclk);
         chk(40'(pulse_divider_value), 40'(d), "divider load");
         repeat (2) wait_hi(2, 4096 * (d + 1) + 100);
         wait_hi(2, 4096 * (d + 1) + 100);
         chk(40'(cyc), 40'(4096 * (d + 1)), "pulse interval");
      end
      end_sim();
   end
endmodule
`default_nettype wire
